/* rtl/hmd_core.sv */
// Purpose: iterative 24x16 multiply and 24/16 divide engine
// Assumes: operands stable in the start cycle only
// Notes:   one step per clock, fixed step count for both operations
`timescale 1ns/1ps
`include "hmd_params.svh"
module hmd_core
  import hmd_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  hmd_if.eng        e
);
  import hmd_pkg::*;

  hmd_state_t  st_q;
  logic [4:0]  cnt_q;
  logic [39:0] work_q;
  logic [39:0] work_d;
  logic [15:0] b_q;
  logic        mode_q;
  logic        done_q;
  logic [16:0] hi_sum;
  logic [17:0] trial;
  logic [23:0] a_cap_q;

  // ****************
  // one step
  // ****************
  // both operations start from {16'h0, a}, so one register serves both
  always_comb begin
    hi_sum = {1'b0, work_q[39:24]} + (work_q[0] ? {1'b0, b_q} : 17'h00000);
    trial  = {1'b0, work_q[39:23]} - {2'b00, b_q};
    work_d = work_q;
    if (mode_q) begin
      work_d = {hi_sum, work_q[23:1]};
    end else if (!trial[17]) begin
      work_d = {trial[15:0], work_q[22:0], 1'b1};
    end else begin
      work_d = {work_q[38:0], 1'b0};
    end
  end

  // ****************
  // sequencing
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 5'h00;
      work_q  <= 40'h0000000000;
      b_q     <= 16'h0000;
      mode_q  <= 1'b0;
      done_q  <= 1'b0;
      a_cap_q <= 24'h000000;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (e.start) begin
            work_q  <= {16'h0000, e.a};
            b_q     <= e.b;
            mode_q  <= e.mode;
            a_cap_q <= e.a;
            cnt_q   <= 5'h00;
            st_q    <= ST_RUN;
          end
        end
        ST_RUN: begin
          work_q <= work_d;
          cnt_q  <= cnt_q + 5'h01;
          // fixed length: no early exit on small operands
          if (cnt_q == `HMD_STEPS - 5'h01) begin
            st_q   <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign e.done   = done_q;
  assign e.result = work_q;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_div_math: assert property (
    done_q && !mode_q && b_q != 16'h0000 |->
      (40'(work_q[23:0]) * 40'(b_q) + 40'(work_q[39:24])) == 40'(a_cap_q)
      && work_q[39:24] < b_q)
    else $error("quotient or remainder wrong");
  chk_mul_math: assert property (
    done_q && mode_q |-> work_q == 40'(a_cap_q) * 40'(b_q))
    else $error("product wrong");
  chk_fixed_latency: assert property (
    st_q == ST_IDLE && e.start |-> !done_q ##25 done_q)
    else $error("operation length not fixed");
endmodule : hmd_core

/* rtl/hmd_if.sv */
// Purpose: launch and result path between register file and engine
// Assumes: one clock
// Notes:   start and done are one-cycle pulses
`timescale 1ns/1ps
interface hmd_if;
  logic        start;
  logic        mode;
  logic [23:0] a;
  logic [15:0] b;
  logic        done;
  logic [39:0] result;
  modport ctl (output start, mode, a, b, input done, result);
  modport eng (input start, mode, a, b, output done, result);
endinterface : hmd_if

/* rtl/hmd_params.svh */
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit register bus
// Notes:   included by the package and the design files
`ifndef HMD_PARAMS_SVH
`define HMD_PARAMS_SVH

// ****************
// register offsets
// ****************
`define HMD_OFF_ACC0   8'h00
`define HMD_OFF_ACC1   8'h04
`define HMD_OFF_ACC2   8'h08
`define HMD_OFF_ACC3   8'h0C
`define HMD_OFF_ACC4   8'h10
`define HMD_OFF_OPBL   8'h14
`define HMD_OFF_OPBH   8'h18
`define HMD_OFF_CTRL   8'h1C
`define HMD_OFF_IRQST  8'h20
`define HMD_OFF_IRQCLR 8'h24
`define HMD_OFF_IRQEN  8'h28

// ****************
// field positions
// ****************
`define HMD_CTRL_SEL     0
`define HMD_CTRL_AUTO    1
`define HMD_CTRL_STARTED 2
`define HMD_CTRL_BUSY    3
`define HMD_IRQ_DONE     0

// ****************
// reset values and counts
// ****************
`define HMD_CTRL_RST   4'h0
`define HMD_BYTE_RST   8'h00
`define HMD_STEPS      5'h18
`define HMD_RESP_OKAY  2'h0
`define HMD_RESP_SLV   2'h2

`endif

/* rtl/hmd_pkg.sv */
// Purpose: shared types of the multiply/divide unit
// Assumes: constants come from hmd_params.svh
// Notes:   types only
`include "hmd_params.svh"
package hmd_pkg;
  typedef logic [31:0] hmd_word_t;
  typedef logic [7:0]  hmd_addr_t;
  typedef logic [1:0]  hmd_resp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } hmd_state_t;
  typedef enum logic [3:0] {
    R_ACC0, R_ACC1, R_ACC2, R_ACC3, R_ACC4,
    R_OPBL, R_OPBH, R_CTRL, R_IRQST, R_IRQCLR, R_IRQEN, R_NONE
  } hmd_reg_t;
endpackage : hmd_pkg

/* rtl/hmd_top.sv */
// Purpose: multiply/divide unit with AXI4-Lite register slave
// Assumes: single clock, synchronous active-low reset
// Notes:   byte-wide registers sit in bits 7:0 of each word
//
// How it works
// - a division takes its 24-bit dividend from acc bytes 2..0 and divisor from operand b.
// - a finished division leaves the quotient in acc bytes 2..0, remainder in bytes 4..3.
// - auto start is in force while auto_start_enable is set in the control register.
// - in auto mode with divide selected, a write to operand_b_low starts a division and sets both status flags.
// - op_in_progress falls by itself when a division finishes.
// - software writing op_in_progress high starts the selected operation and sets the flag.
// - op_started_flag is only ever cleared by a software write of the control register.
// - op_select high picks multiplication, low picks division.
// - a multiplication takes a 24-bit multiplicand from acc bytes 2..0, multiplier from b.
// - a finished multiplication leaves the 40-bit product in acc bytes 4..0.
// - in auto mode with multiply selected, writing operand_b_low starts a multiplication.
// - op_in_progress falls by itself when a multiplication finishes.
`timescale 1ns/1ps
`include "hmd_params.svh"
module hmd_top
  import hmd_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire hmd_pkg::hmd_addr_t awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire hmd_pkg::hmd_word_t wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output hmd_pkg::hmd_resp_t      bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire hmd_pkg::hmd_addr_t araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output hmd_pkg::hmd_word_t      rdata,
  output hmd_pkg::hmd_resp_t      rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic                    irq
);
  import hmd_pkg::*;

  // ****************
  // decode
  // ****************
  function automatic hmd_reg_t reg_of(input hmd_addr_t a);
    unique case (a)
      `HMD_OFF_ACC0:   return R_ACC0;
      `HMD_OFF_ACC1:   return R_ACC1;
      `HMD_OFF_ACC2:   return R_ACC2;
      `HMD_OFF_ACC3:   return R_ACC3;
      `HMD_OFF_ACC4:   return R_ACC4;
      `HMD_OFF_OPBL:   return R_OPBL;
      `HMD_OFF_OPBH:   return R_OPBH;
      `HMD_OFF_CTRL:   return R_CTRL;
      `HMD_OFF_IRQST:  return R_IRQST;
      `HMD_OFF_IRQCLR: return R_IRQCLR;
      `HMD_OFF_IRQEN:  return R_IRQEN;
      default:         return R_NONE;
    endcase
  endfunction : reg_of

  logic            awready_q;
  logic            wready_q;
  logic            bvalid_q;
  hmd_resp_t       bresp_q;
  hmd_addr_t       awaddr_q;
  logic [7:0]      wbyte_q;
  logic            wen_q;
  logic            arready_q;
  logic            rvalid_q;
  hmd_word_t       rdata_q;
  hmd_resp_t       rresp_q;
  hmd_word_t       rd_mux;
  hmd_reg_t        wr_sel;
  hmd_reg_t        ar_sel;
  logic            wr_go;
  logic            wr;
  logic            wr_ctrl;
  logic            trig;
  logic [4:0][7:0] acc_q;
  logic [7:0]      opbl_q;
  logic [7:0]      opbh_q;
  logic            sel_q;
  logic            auto_q;
  logic            started_q;
  logic            busy_q;
  logic            start_q;
  logic            status_q;
  logic            enable_q;
  logic            irq_q;
  logic [3:0]      ctrl_rd;

  hmd_if ifc ();

  // ****************
  // write channel
  // ****************
  // address and data may arrive in either order; both are held until the
  // response is taken, so one write at a time is ever in flight
  assign wr_sel  = reg_of(awaddr_q);
  assign wr_go   = !awready_q && !wready_q && !bvalid_q;
  assign wr      = wr_go && wen_q;
  assign wr_ctrl = wr && wr_sel == R_CTRL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `HMD_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wbyte_q   <= `HMD_BYTE_RST;
      wen_q     <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wbyte_q  <= wdata[7:0];
        wen_q    <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == R_NONE) ? `HMD_RESP_SLV : `HMD_RESP_OKAY;
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ****************
  // read channel
  // ****************
  assign ar_sel = reg_of(araddr);

  always_comb begin
    ctrl_rd                    = 4'h0;
    ctrl_rd[`HMD_CTRL_SEL]     = sel_q;
    ctrl_rd[`HMD_CTRL_AUTO]    = auto_q;
    ctrl_rd[`HMD_CTRL_STARTED] = started_q;
    ctrl_rd[`HMD_CTRL_BUSY]    = busy_q;
    rd_mux                     = 32'h00000000;
    unique case (ar_sel)
      R_ACC0, R_ACC1, R_ACC2, R_ACC3, R_ACC4: rd_mux = {24'h000000, acc_q[ar_sel[2:0]]};
      R_OPBL:  rd_mux = {24'h000000, opbl_q};
      R_OPBH:  rd_mux = {24'h000000, opbh_q};
      R_CTRL:  rd_mux = {28'h0000000, ctrl_rd};
      R_IRQST: rd_mux = {31'h00000000, status_q};
      R_IRQEN: rd_mux = {31'h00000000, enable_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `HMD_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= (ar_sel == R_NONE) ? `HMD_RESP_SLV : `HMD_RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ****************
  // operand and result bytes
  // ****************
  // a finishing operation wins over a software write in the same cycle
  for (genvar i = 0; i < 5; i++) begin : g_acc
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_q[i] <= `HMD_BYTE_RST;
      end else if (ifc.done) begin
        acc_q[i] <= ifc.result[8*i +: 8];
      end else if (wr && wr_sel == hmd_reg_t'(i)) begin
        acc_q[i] <= wbyte_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opbl_q <= `HMD_BYTE_RST;
      opbh_q <= `HMD_BYTE_RST;
    end else begin
      if (wr && wr_sel == R_OPBL) begin
        opbl_q <= wbyte_q;
      end
      if (wr && wr_sel == R_OPBH) begin
        opbh_q <= wbyte_q;
      end
    end
  end

  // ****************
  // control and launch
  // ****************
  // a launch while busy is dropped: the engine holds one job only
  // operand_b_high is already stored when the low byte launches
  assign trig = !busy_q &&
                ((wr && wr_sel == R_OPBL && auto_q) ||
                 (wr_ctrl && wbyte_q[`HMD_CTRL_BUSY]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {busy_q, started_q, auto_q, sel_q} <= `HMD_CTRL_RST;
      start_q <= 1'b0;
    end else begin
      start_q <= trig;
      if (wr_ctrl) begin
        sel_q     <= wbyte_q[`HMD_CTRL_SEL];
        auto_q    <= wbyte_q[`HMD_CTRL_AUTO];
        started_q <= wbyte_q[`HMD_CTRL_STARTED];
      end
      if (trig) begin
        busy_q    <= 1'b1;
        started_q <= 1'b1;
      end else if (ifc.done) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign ifc.start = start_q;
  assign ifc.mode  = sel_q;
  assign ifc.a     = {acc_q[2], acc_q[1], acc_q[0]};
  assign ifc.b     = {opbh_q, opbl_q};

  hmd_core u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .e       (ifc.eng)
  );

  // ****************
  // interrupt
  // ****************
  // completion wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 1'b0;
      enable_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      irq_q <= status_q && enable_q;
      if (wr && wr_sel == R_IRQEN) begin
        enable_q <= wbyte_q[`HMD_IRQ_DONE];
      end
      if (ifc.done) begin
        status_q <= 1'b1;
      end else if (wr && wr_sel == R_IRQCLR && wbyte_q[`HMD_IRQ_DONE]) begin
        status_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign irq     = irq_q;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_auto_launch: assert property (
    wr && wr_sel == R_OPBL && auto_q && !busy_q |=> busy_q && started_q && start_q)
    else $error("auto launch missed");
  chk_auto_gate: assert property (
    wr && wr_sel == R_OPBL && !auto_q |=> !start_q)
    else $error("launch without auto start");
  chk_flag_launch: assert property (
    wr_ctrl && wbyte_q[`HMD_CTRL_BUSY] && !busy_q |=> busy_q && started_q && start_q ##1 !start_q)
    else $error("flag launch missed");
  chk_busy_clear: assert property (
    ifc.done |=> !busy_q)
    else $error("busy not cleared on completion");
  chk_busy_span: assert property (
    $rose(busy_q) |-> ##25 busy_q ##1 !busy_q)
    else $error("busy length wrong");
  chk_started_hold: assert property (
    started_q && !wr_ctrl |=> started_q)
    else $error("started flag cleared by hardware");
  chk_result_load: assert property (
    ifc.done |=> acc_q == $past(ifc.result))
    else $error("result not loaded");
  chk_irq_level: assert property (
    status_q && enable_q |=> irq_q)
    else $error("interrupt not raised");

  cov_auto_mul: cover property (wr && wr_sel == R_OPBL && auto_q && sel_q && !busy_q);
  cov_flag_div: cover property (wr_ctrl && wbyte_q[`HMD_CTRL_BUSY] && !sel_q && !busy_q);
  cov_irq:      cover property ($rose(irq_q));
endmodule : hmd_top

/* rtl/hmd_unused_marker.sv */
// Purpose: none
// Assumes: none
// Notes:   intentionally empty
`timescale 1ns/1ps

/* tb/hmd_host.sv */
// Purpose: host core model issuing register cycles on the bus
// Assumes: one write and one read outstanding at most
// Notes:   waits are bounded; a timeout is handed back to the caller
`timescale 1ns/1ps
module hmd_host
  import hmd_pkg::*;
(
  input  wire logic          aclk,
  output hmd_pkg::hmd_addr_t awaddr,
  output logic               awvalid,
  input  wire logic          awready,
  output hmd_pkg::hmd_word_t wdata,
  output logic [3:0]         wstrb,
  output logic               wvalid,
  input  wire logic          wready,
  input  wire hmd_pkg::hmd_resp_t bresp,
  input  wire logic          bvalid,
  output logic               bready,
  output hmd_pkg::hmd_addr_t araddr,
  output logic               arvalid,
  input  wire logic          arready,
  input  wire hmd_pkg::hmd_word_t rdata,
  input  wire hmd_pkg::hmd_resp_t rresp,
  input  wire logic          rvalid,
  output logic               rready
);
  // ****************
  // idle bus
  // ****************
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // ****************
  // bus cycles
  // ****************
  // address and data offered together, each dropped when taken
  task automatic wr(input hmd_addr_t a, input logic [7:0] d, output hmd_resp_t r,
                    output logic to);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    to = 1'b1;
    r = 2'h0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge aclk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
      if (!aw_p && !w_p && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        to = 1'b0;
      end
    end
    // one idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input hmd_addr_t a, output hmd_word_t d, output hmd_resp_t r,
                    output logic to);
    logic ar_p;
    ar_p = 1'b1;
    to = 1'b1;
    d = 32'h00000000;
    r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge aclk);
      if (ar_p && arready) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end else if (!ar_p && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        to = 1'b0;
      end
    end
    // one idle edge so a following call never re-drives rready in this step
    @(posedge aclk);
  endtask : rd
endmodule : hmd_host

/* tb/hw_multiply_divide_unit_bench.sv */
// Purpose: self-checking bench of the multiply/divide unit
// Assumes: host model drives the register bus
// Notes:   results are read only after op_in_progress falls
`timescale 1ns/1ps
`include "hmd_params.svh"
module hw_multiply_divide_unit_bench;
  import hmd_pkg::*;
  logic       aclk;
  logic       aresetn;
  hmd_addr_t  awaddr, araddr;
  hmd_word_t  wdata, rdata;
  hmd_resp_t  bresp, rresp, resp;
  logic [3:0] wstrb;
  logic       awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready, irq;
  int         n_errors;
  int         total_checks;

  hmd_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq));
  hmd_host host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************
  // reporting
  // ****************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic hang();
    n_errors++;
    $display("mismatch at %0t: wait timed out", $time);
    finish_test();
  endtask : hang

  task automatic wreg(input hmd_addr_t a, input logic [7:0] d);
    logic to;
    host_u.wr(a, d, resp, to);
    if (to) hang();
  endtask : wreg

  task automatic rreg(input hmd_addr_t a, output hmd_word_t d);
    logic to;
    host_u.rd(a, d, resp, to);
    if (to) hang();
  endtask : rreg

  function automatic logic [39:0] expect_of(input logic mul, input logic [23:0] a,
                                            input logic [15:0] b);
    if (mul) return {16'h0000, a} * {24'h000000, b};
    return {16'(a % {8'h00, b}), 24'(a / {8'h00, b})};
  endfunction : expect_of

  // ****************
  // operations
  // ****************
  // launch by auto write or busy flag, then poll until the unit is idle
  task automatic run_op(input logic mul, input logic au, input logic [23:0] a,
                        input logic [15:0] b, output logic [39:0] res);
    hmd_word_t v;
    int n;
    wreg(`HMD_OFF_CTRL, {6'h00, au, mul});
    wreg(`HMD_OFF_ACC0, a[7:0]);
    wreg(`HMD_OFF_ACC1, a[15:8]);
    wreg(`HMD_OFF_ACC2, a[23:16]);
    wreg(`HMD_OFF_OPBH, b[15:8]);
    wreg(`HMD_OFF_OPBL, b[7:0]);
    if (!au) begin
      wreg(`HMD_OFF_CTRL, {4'h0, 2'b10, au, mul});
    end
    rreg(`HMD_OFF_CTRL, v);
    chk({38'h0, v[3:2]}, 40'h3, "launch flags");
    n = 0;
    while (v[3] !== 1'b0 && n < 100) begin
      rreg(`HMD_OFF_CTRL, v);
      n++;
    end
    if (v[3] !== 1'b0) hang();
    chk({39'h0, v[2]}, 40'h1, "started flag kept");
    for (int i = 0; i < 5; i++) begin
      rreg(`HMD_OFF_ACC0 + 8'(i * 4), v);
      res[8 * i +: 8] = v[7:0];
    end
  endtask : run_op

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    hmd_word_t v;
    rreg(`HMD_OFF_CTRL, v);
    chk({8'h00, v}, 40'h0, "control after reset");
    rreg(`HMD_OFF_ACC4, v);
    chk({8'h00, v}, 40'h0, "acc after reset");
    chk({39'h0, irq}, 40'h0, "irq after reset");
    $display("done reset test");
  endtask : t_reset

  // every mode with both start methods, boundary operands
  task automatic t_ops();
    logic [39:0] res;
    logic [23:0] av [4] = '{24'hABCDEF, 24'hFFFFFF, 24'h000123, 24'hFFFFFF};
    logic [15:0] bv [4] = '{16'h1234, 16'h0001, 16'h0456, 16'hFFFF};
    for (int i = 0; i < 4; i++) begin
      run_op(i[0], i[1], av[i], bv[i], res);
      chk(res, expect_of(i[0], av[i], bv[i]), "result");
    end
    $display("done operation test");
  endtask : t_ops

  task automatic t_no_auto();
    hmd_word_t v;
    wreg(`HMD_OFF_CTRL, 8'h00);
    rreg(`HMD_OFF_CTRL, v);
    chk({38'h0, v[3:2]}, 40'h0, "software clear of flags");
    wreg(`HMD_OFF_OPBL, 8'h05);
    rreg(`HMD_OFF_CTRL, v);
    chk({8'h00, v}, 40'h0, "no launch without auto");
    $display("done manual mode test");
  endtask : t_no_auto

  task automatic t_irq();
    logic [39:0] res;
    hmd_word_t v;
    wreg(`HMD_OFF_IRQEN, 8'h01);
    run_op(1'b1, 1'b1, 24'h000002, 16'h0003, res);
    chk({39'h0, irq}, 40'h1, "irq raised");
    wreg(`HMD_OFF_IRQCLR, 8'h01);
    rreg(`HMD_OFF_IRQST, v);
    chk({8'h00, v}, 40'h0, "status cleared");
    chk({39'h0, irq}, 40'h0, "irq dropped");
    wreg(`HMD_OFF_IRQEN, 8'h00);
    run_op(1'b0, 1'b0, 24'h000009, 16'h0002, res);
    chk({39'h0, irq}, 40'h0, "irq masked");
    rreg(`HMD_OFF_IRQST, v);
    chk({8'h00, v}, 40'h1, "status sticky");
    wreg(`HMD_OFF_IRQCLR, 8'h01);
    $display("done interrupt test");
  endtask : t_irq

  task automatic t_bus();
    hmd_word_t v;
    wreg(8'h2C, 8'hFF);
    chk({38'h0, resp}, {38'h0, `HMD_RESP_SLV}, "unmapped write");
    rreg(8'h2C, v);
    chk({38'h0, resp}, {38'h0, `HMD_RESP_SLV}, "unmapped read");
    chk({8'h00, v}, 40'h0, "unmapped data");
    $display("done bus test");
  endtask : t_bus

  initial begin
    n_errors = 0;
    total_checks = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ops();
    t_no_auto();
    t_irq();
    t_bus();
    finish_test();
  end
endmodule : hw_multiply_divide_unit_bench
